// [smcr_map.vh]
// Register indices, field positions and reset values of the master control
// bank. Assumes an AHB-Lite slave where byte address equals four times index.
//
// Notes on behaviour
// - Label mismatch raises aux defect only while extended defect mode is set.
// - Unequipped enable gates aux defect for unequipped tributaries.
// - Pointer loss disable suppresses aux defect, overriding all enables.
// - Incoming alarm disable suppresses aux defect, overriding all enables.
// - Multiframe loss disable suppresses aux defect for those tributaries.
// - Frequency select 1 means 51.84MHz, 0 means 44.928MHz; resets 0.
// - Frame source 0 uses line markers, 1 uses system add/drop pulses.
// - Transparent tributaries need frame source 1; pointer processors align.
// - Line loopback bit loops whole received line out egress bus.
// - Diagnostic loopback bit loops egress envelopes back into ingress path.
// - Diagnostic loopback acts only on envelopes carrying low-order tributaries.
// - Activity bits set on rising edges, stay set, all clear on read.
// - Drop data bit sets only after every data line rose since read.
// - Monitor write ends accumulation interval, activity bits unchanged.
// - Ten-bit transmit pointer sets add bus payload offset; resets 522.
// - Delay-line error enable drives active-low interrupt on error status.
// - Label unstable enable gates aux defect for unstable tributaries.
`ifndef SMCR_MAP_VH
`define SMCR_MAP_VH

// ------------------------------------------------------------
// Register indices
// ------------------------------------------------------------
`define SMCR_IDX_AUXDEF 12'h708
`define SMCR_IDX_CLKSRC 12'h709
`define SMCR_IDX_LOOP 12'h70A
`define SMCR_IDX_MON 12'h70B
`define SMCR_IDX_PTRH 12'h70C
`define SMCR_IDX_PTRL 12'h70D
`define SMCR_IDX_DLL 12'h73C

// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define SMCR_B_NOLOM 7
`define SMCR_B_NOLOP 6
`define SMCR_B_NOAIS 5
`define SMCR_B_UNEQ 4
`define SMCR_B_PSLM 3
`define SMCR_B_PSLU 2
`define SMCR_B_FREQ 7
`define SMCR_B_FPSEL 0
`define SMCR_B_LOOPRSV 7
`define SMCR_B_DIAG_LOOPBACK_EN 1
`define SMCR_B_LINE_LOOPBACK_EN 0
`define SMCR_B_ERRE 2
`define SMCR_B_DROP_MK 0
`define SMCR_B_PL 1
`define SMCR_B_TPL 2
`define SMCR_B_POH 3
`define SMCR_B_DDA 4
`define SMCR_B_ADD_MK 5
`define SMCR_B_EAST 6
`define SMCR_B_WEST 7

// ------------------------------------------------------------
// Reset values and masks
// ------------------------------------------------------------
`define SMCR_RST_AUXDEF 6'h38
`define SMCR_RST_PTR 10'h20A
`define SMCR_DLL_RW_MASK 8'h37
`define SMCR_HTRANS_NONSEQ 2'h2

`endif

// [smcr_regs.v]
// Master control and monitor register bank with an AHB-Lite slave port.
// Assumes line-side inputs are synchronous to clk_sys; only the activity monitor
// resynchronises them; tributary alarm states arrive as per-tributary vectors.
`timescale 1ns/1ps
`include "smcr_map.vh"

module smcr_regs #(
   parameter N_TRIB = 84,
   parameter N_SPE = 3
) (
   input wire clk_sys, // System clock, 125 MHz
   input wire resetn, // Asynchronous reset, active low
   input wire hsel, // Slave select
   input wire [13:0] haddr, // Byte address
   input wire [1:0] htrans, // Transfer type
   input wire hwrite, // Write strobe
   input wire [2:0] hsize, // Transfer size, word only
   input wire [31:0] hwdata, // Write data
   input wire hready, // Bus ready
   output wire hreadyout, // Slave ready
   output wire hresp, // Always OKAY
   output wire [31:0] hrdata, // Read data
   input wire extended_defect_mode, // Extended defect bit of alarm proc
   input wire [N_TRIB-1:0] trib_label_mismatch, // Per tributary state
   input wire [N_TRIB-1:0] trib_label_unstable, // Per tributary state
   input wire [N_TRIB-1:0] trib_unequipped, // Per tributary state
   input wire [N_TRIB-1:0] trib_pointer_loss, // Per tributary state
   input wire [N_TRIB-1:0] trib_incoming_alarm, // Per tributary state
   input wire [N_TRIB-1:0] trib_multiframe_loss, // Per tributary state
   output wire [N_TRIB-1:0] aux_defect, // Aux defect reports
   output wire fast_ref_freq_select, // 1: 51.84MHz, 0: 44.928MHz
   output wire system_frame_pulse_select, // Frame source select
   input wire system_add_frame_pulse, // System add frame pulse
   input wire system_drop_frame_pulse, // System drop frame pulse
   input wire line_add_frame_marker, // Line add frame marker
   input wire line_drop_frame_marker, // Line drop frame marker
   output wire mapper_add_frame_sync, // Selected add frame sync
   output wire mapper_drop_frame_sync, // Selected drop frame sync
   output wire line_loopback_en, // Line loopback active
   output wire diag_loopback_en, // Diagnostic loopback bit
   input wire [N_SPE-1:0] spe_carries_lo_trib, // SPE carries VT/TU
   output wire [N_SPE-1:0] diag_loopback_spe, // Per-SPE loopback
   input wire line_drop_payload_marker, // Monitored input
   input wire line_drop_trib_payload_marker, // Monitored input
   input wire line_drop_path_overhead_marker, // Monitored input
   input wire [7:0] line_drop_data_bus, // Monitored data lines
   input wire east_alarm_link_clock, // Monitored clock
   input wire west_alarm_link_clock, // Monitored clock
   output wire accum_trigger, // One-cycle interval end pulse
   output wire [9:0] transmit_payload_pointer, // Add bus payload offset
   input wire delay_line_error, // Delay-line error status
   output wire delay_line_error_irq_en, // Enable bit
   output wire interrupt_out_n // Interrupt, active low
);

   // ------------------------------------------------------------
   // Bus decode
   // ------------------------------------------------------------
   // Index match used by both read and write paths
   function is_idx;
      input [11:0] a;
      input [11:0] idx;
      begin
         is_idx = (a == idx);
      end
   endfunction

   reg hready_q;
   reg [7:0] hrdata_q;
   reg hresp_q;
   reg wr_pend_q;
   reg [11:0] wr_idx_q;
   wire [11:0] idx;
   wire take;
   wire rd_take;
   wire wr_now;
   wire mon_read;

   // Address phase accepted only on NONSEQ with the bus ready
   assign idx = haddr[13:2];
   assign take = hsel & hready & (htrans == `SMCR_HTRANS_NONSEQ);
   assign rd_take = take & ~hwrite;
   assign wr_now = wr_pend_q;
   assign mon_read = rd_take & is_idx(idx, `SMCR_IDX_MON);

   // Write address held into the data phase, where hwdata stands
   always @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         wr_pend_q <= 1'b0;
         wr_idx_q <= 12'h000;
         hresp_q <= 1'b0;
         hready_q <= 1'b1;
      end else begin
         wr_pend_q <= take & hwrite;
         wr_idx_q <= idx;
         hresp_q <= 1'b0;
         hready_q <= 1'b1; // Never inserts wait states
      end
   end

   // ------------------------------------------------------------
   // Control registers
   // ------------------------------------------------------------
   reg [5:0] auxdef_q;
   reg freq_q;
   reg fpsel_q;
   reg loop_rsv_q;
   reg diag_loopback_en_q;
   reg line_loopback_en_q;
   reg [9:0] ptr_q;
   reg [7:0] dll_q;
   reg trig_q;

   // Software writes; only the reserved loopback bit is kept so it reads back
   always @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         auxdef_q <= `SMCR_RST_AUXDEF;
         freq_q <= 1'b0;
         fpsel_q <= 1'b0;
         loop_rsv_q <= 1'b0;
         diag_loopback_en_q <= 1'b0;
         line_loopback_en_q <= 1'b0;
         ptr_q <= `SMCR_RST_PTR;
         dll_q <= 8'h00;
         trig_q <= 1'b0;
      end else begin
         trig_q <= wr_now & is_idx(wr_idx_q, `SMCR_IDX_MON);
         if (wr_now) begin
            if (is_idx(wr_idx_q, `SMCR_IDX_AUXDEF)) begin
               auxdef_q <= hwdata[7:2];
            end
            if (is_idx(wr_idx_q, `SMCR_IDX_CLKSRC)) begin
               freq_q <= hwdata[`SMCR_B_FREQ];
               fpsel_q <= hwdata[`SMCR_B_FPSEL];
            end
            if (is_idx(wr_idx_q, `SMCR_IDX_LOOP)) begin
               loop_rsv_q <= hwdata[`SMCR_B_LOOPRSV];
               diag_loopback_en_q <= hwdata[`SMCR_B_DIAG_LOOPBACK_EN];
               line_loopback_en_q <= hwdata[`SMCR_B_LINE_LOOPBACK_EN];
            end
            if (is_idx(wr_idx_q, `SMCR_IDX_PTRH)) begin
               ptr_q[9:8] <= hwdata[1:0];
            end
            if (is_idx(wr_idx_q, `SMCR_IDX_PTRL)) begin
               ptr_q[7:0] <= hwdata[7:0];
            end
            if (is_idx(wr_idx_q, `SMCR_IDX_DLL)) begin
               dll_q <= hwdata[7:0] & `SMCR_DLL_RW_MASK;
            end
         end
      end
   end

   // ------------------------------------------------------------
   // Activity monitor
   // ------------------------------------------------------------
   // Bits: 0 drop mk, 1 payload, 2 trib payload, 3 path oh, 4-11 data,
   // 12 add mk, 13 east clk, 14 west clk
   wire [14:0] mon_in;
   reg [14:0] sync1_q;
   reg [14:0] sync2_q;
   reg [14:0] sync3_q;
   wire [14:0] rise;
   reg [7:0] act_q;
   reg [7:0] act_d;
   reg [7:0] seen_q;
   reg [7:0] seen_d;
   wire [7:0] seen_all;
   wire [7:0] set_v;

   assign mon_in = {west_alarm_link_clock, east_alarm_link_clock,
      line_add_frame_marker, line_drop_data_bus,
      line_drop_path_overhead_marker, line_drop_trib_payload_marker,
      line_drop_payload_marker, line_drop_frame_marker};

   // Two-stage sync then one more stage for the edge compare
   always @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         sync1_q <= 15'h0000;
         sync2_q <= 15'h0000;
         sync3_q <= 15'h0000;
      end else begin
         sync1_q <= mon_in;
         sync2_q <= sync1_q;
         sync3_q <= sync2_q;
      end
   end

   assign rise = sync2_q & ~sync3_q;
   assign seen_all = seen_q | rise[11:4];

   assign set_v = {rise[14], rise[13], rise[12], &seen_all,
      rise[3], rise[2], rise[1], rise[0]};

   // Set wins over the clearing read so no edge is lost
   always @* begin
      act_d = (mon_read ? 8'h00 : act_q) | set_v;
      seen_d = mon_read ? rise[11:4] : seen_all;
      if (&seen_all) begin
         seen_d = 8'h00;
      end
   end

   always @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         act_q <= 8'h00;
         seen_q <= 8'h00;
      end else begin
         act_q <= act_d;
         seen_q <= seen_d;
      end
   end

   // ------------------------------------------------------------
   // Read data
   // ------------------------------------------------------------
   // Captured at the address phase so the data phase needs no wait
   always @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         hrdata_q <= 8'h00;
      end else if (rd_take) begin
         case (1'b1)
            is_idx(idx, `SMCR_IDX_AUXDEF): hrdata_q <= {auxdef_q, 2'h0};
            is_idx(idx, `SMCR_IDX_CLKSRC):
               hrdata_q <= {freq_q, 6'h00, fpsel_q};
            is_idx(idx, `SMCR_IDX_LOOP):
               hrdata_q <= {loop_rsv_q, 5'h00, diag_loopback_en_q, line_loopback_en_q};
            is_idx(idx, `SMCR_IDX_MON): hrdata_q <= act_q;
            is_idx(idx, `SMCR_IDX_PTRH): hrdata_q <= {6'h00, ptr_q[9:8]};
            is_idx(idx, `SMCR_IDX_PTRL): hrdata_q <= ptr_q[7:0];
            is_idx(idx, `SMCR_IDX_DLL): hrdata_q <= dll_q;
            default: hrdata_q <= 8'h00;
         endcase
      end
   end

   // ------------------------------------------------------------
   // Aux defect reporting
   // ------------------------------------------------------------
   reg [N_TRIB-1:0] aux_q;
   genvar g;
   generate
      for (g = 0; g < N_TRIB; g = g + 1) begin : g_trib
         wire raise;
         wire block;
         assign raise =
            (auxdef_q[`SMCR_B_PSLM-2] & extended_defect_mode &
             trib_label_mismatch[g]) |
            (auxdef_q[`SMCR_B_UNEQ-2] & trib_unequipped[g]) |
            (auxdef_q[`SMCR_B_PSLU-2] & trib_label_unstable[g]);
         assign block =
            (auxdef_q[`SMCR_B_NOLOP-2] & trib_pointer_loss[g]) |
            (auxdef_q[`SMCR_B_NOAIS-2] & trib_incoming_alarm[g]) |
            (auxdef_q[`SMCR_B_NOLOM-2] & trib_multiframe_loss[g]);
         always @(posedge clk_sys or negedge resetn) begin
            if (!resetn) begin
               aux_q[g] <= 1'b0;
            end else begin
               aux_q[g] <= raise & ~block;
            end
         end
      end
   endgenerate

   // ------------------------------------------------------------
   // Frame sync, loopback and interrupt outputs
   // ------------------------------------------------------------
   reg add_sync_q;
   reg drop_sync_q;
   reg [N_SPE-1:0] dspe_q;
   reg irq_n_q;

   // Mapper frame source; the system pulses assume equal ref clocks
   always @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         add_sync_q <= 1'b0;
         drop_sync_q <= 1'b0;
         dspe_q <= {N_SPE{1'b0}};
         irq_n_q <= 1'b1;
      end else begin
         add_sync_q <= fpsel_q ? system_add_frame_pulse :
            line_add_frame_marker;
         drop_sync_q <= fpsel_q ? system_drop_frame_pulse :
            line_drop_frame_marker;
         dspe_q <= {N_SPE{diag_loopback_en_q}} & spe_carries_lo_trib;
         irq_n_q <= ~(dll_q[`SMCR_B_ERRE] & delay_line_error);
      end
   end

   // ------------------------------------------------------------
   // Output drive
   // ------------------------------------------------------------
   assign hreadyout = hready_q;
   assign hresp = hresp_q;
   assign hrdata = {24'h000000, hrdata_q};
   assign aux_defect = aux_q;
   assign fast_ref_freq_select = freq_q;
   assign system_frame_pulse_select = fpsel_q;
   assign mapper_add_frame_sync = add_sync_q;
   assign mapper_drop_frame_sync = drop_sync_q;
   assign line_loopback_en = line_loopback_en_q;
   assign diag_loopback_en = diag_loopback_en_q;
   assign diag_loopback_spe = dspe_q;
   assign accum_trigger = trig_q;
   assign transmit_payload_pointer = ptr_q;
   assign delay_line_error_irq_en = dll_q[`SMCR_B_ERRE];
   assign interrupt_out_n = irq_n_q;

endmodule // smcr_regs

// [smcr_regs_asserts.sv]
// Concurrent checks on the ports of the master control register bank.
// Assumes binding into smcr_regs: one clock, asynchronous active-low reset.
`timescale 1ns/1ps
`include "smcr_map.vh"
module smcr_regs_asserts #(
   parameter N_TRIB = 84,
   parameter N_SPE = 3
) (
   input wire clk_sys, // Clock
   input wire resetn, // Reset
   input wire hsel, // Bus
   input wire [13:0] haddr, // Bus
   input wire [1:0] htrans, // Bus
   input wire hwrite, // Bus
   input wire hready, // Bus
   input wire hreadyout, // Bus
   input wire hresp, // Bus
   input wire extended_defect_mode, // Alarm
   input wire [N_TRIB-1:0] trib_label_mismatch, // Alarm
   input wire [N_TRIB-1:0] trib_label_unstable, // Alarm
   input wire [N_TRIB-1:0] trib_unequipped, // Alarm
   input wire [N_TRIB-1:0] aux_defect, // Report
   input wire fast_ref_freq_select, // Config
   input wire system_frame_pulse_select, // Config
   input wire system_add_frame_pulse, // Frame
   input wire system_drop_frame_pulse, // Frame
   input wire line_add_frame_marker, // Frame
   input wire line_drop_frame_marker, // Frame
   input wire mapper_add_frame_sync, // Frame
   input wire mapper_drop_frame_sync, // Frame
   input wire diag_loopback_en, // Loop
   input wire [N_SPE-1:0] spe_carries_lo_trib, // Loop
   input wire [N_SPE-1:0] diag_loopback_spe, // Loop
   input wire accum_trigger, // Monitor
   input wire [9:0] transmit_payload_pointer, // Pointer
   input wire delay_line_error, // Irq
   input wire delay_line_error_irq_en, // Irq
   input wire interrupt_out_n // Irq
);
   // ----------------------------------------
   // Port relations
   // ----------------------------------------
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!resetn);
   // Monitor writes are the only cause of an accumulation pulse
   wire mon_wr = hsel && hready && htrans == `SMCR_HTRANS_NONSEQ && hwrite &&
      haddr[13:2] == `SMCR_IDX_MON;
   a_bus_no_wait: assert property (hreadyout && !hresp)
      else $error("slave stalled or flagged an error");
   a_reset_values: assert property (!$past(resetn) |->
      transmit_payload_pointer == 10'h20A && !fast_ref_freq_select)
      else $error("pointer or frequency select wrong after reset");
   a_aux_has_cause: assert property ($past(resetn) |->
      (aux_defect & ~$past((trib_label_mismatch &
      {N_TRIB{extended_defect_mode}}) | trib_unequipped |
      trib_label_unstable)) == {N_TRIB{1'b0}})
      else $error("aux defect without an enabled cause");
   a_add_sync_src: assert property ($past(resetn) |->
      mapper_add_frame_sync == $past(system_frame_pulse_select ?
      system_add_frame_pulse : line_add_frame_marker))
      else $error("add frame sync from wrong source");
   a_drop_sync_src: assert property ($past(resetn) |->
      mapper_drop_frame_sync == $past(system_frame_pulse_select ?
      system_drop_frame_pulse : line_drop_frame_marker))
      else $error("drop frame sync from wrong source");
   a_diag_per_spe: assert property ($past(resetn) |->
      diag_loopback_spe == ($past(spe_carries_lo_trib) &
      {N_SPE{$past(diag_loopback_en)}}))
      else $error("diagnostic loopback on wrong payloads");
   a_irq_follows: assert property ($past(resetn) |->
      interrupt_out_n == !$past(delay_line_error_irq_en && delay_line_error))
      else $error("interrupt level wrong");
   a_accum_on_write: assert property (mon_wr |-> ##2 accum_trigger ##1
      !accum_trigger)
      else $error("accumulation pulse missing or too long");
   a_accum_cause: assert property (accum_trigger |-> $past(mon_wr, 2))
      else $error("accumulation pulse without monitor write");
endmodule // smcr_regs_asserts

bind smcr_regs smcr_regs_asserts #(.N_TRIB(N_TRIB), .N_SPE(N_SPE)) u_chk (.*);

// [smcr_regs_tb_top.sv]
// Self-checking bench for the master control register bank.
// Assumes a single word AHB-Lite master and the bound port checker.
`timescale 1ns/1ps
`include "smcr_map.vh"
module smcr_regs_tb_top;
   localparam NT = 8;
   reg clk_sys = 1'b0;
   reg resetn = 1'b0;
   reg hsel = 1'b0;
   reg hwrite = 1'b0;
   reg [13:0] haddr = 14'h0;
   reg [1:0] htrans = 2'h0;
   reg [2:0] hsize = 3'h2;
   reg [31:0] hwdata = 32'h0;
   wire hready, hreadyout, hresp;
   wire [31:0] hrdata;
   reg extended_defect_mode = 1'b0;
   reg [NT-1:0] trib_label_mismatch = 0, trib_label_unstable = 0;
   reg [NT-1:0] trib_unequipped = 0, trib_pointer_loss = 0;
   reg [NT-1:0] trib_incoming_alarm = 0, trib_multiframe_loss = 0;
   wire [NT-1:0] aux_defect;
   reg system_add_frame_pulse = 1'b0, system_drop_frame_pulse = 1'b0;
   reg [2:0] spe_carries_lo_trib = 3'h0;
   reg delay_line_error = 1'b0;
   reg [7:0] mon = 8'h00; // Monitored lines in monitor bit order
   reg [7:0] line_drop_data_bus = 8'h00;
   wire line_drop_frame_marker = mon[0];
   wire line_drop_payload_marker = mon[1];
   wire line_drop_trib_payload_marker = mon[2];
   wire line_drop_path_overhead_marker = mon[3];
   wire line_add_frame_marker = mon[5];
   wire east_alarm_link_clock = mon[6];
   wire west_alarm_link_clock = mon[7];
   wire [2:0] diag_loopback_spe;
   wire [9:0] transmit_payload_pointer;
   wire fast_ref_freq_select, system_frame_pulse_select, line_loopback_en;
   wire diag_loopback_en, delay_line_error_irq_en, interrupt_out_n;
   wire mapper_add_frame_sync, mapper_drop_frame_sync, accum_trigger;
   integer seed = 32'h2dc56637;
   integer failures = 0;
   integer tests_run = 0;
   integer i, k;
   reg [31:0] rd;
   reg [27:0] info;
   reg [7:0] v;
   assign hready = hreadyout;
   always #4 clk_sys = ~clk_sys;
   smcr_regs #(.N_TRIB(NT), .N_SPE(3)) dut (.*);
   // Free-running random traffic on frame pulses, payload kinds and error
   always @(posedge clk_sys) begin
      system_add_frame_pulse <= $random(seed);
      system_drop_frame_pulse <= $random(seed);
      spe_carries_lo_trib <= $random(seed);
      delay_line_error <= $random(seed);
   end
   // Index, reset value and writable mask; last entry is unmapped
   function [27:0] reg_info(input integer n);
      case (n)
         0: reg_info = {12'h708, 8'hE0, 8'hFC};
         1: reg_info = {12'h709, 8'h00, 8'h81};
         2: reg_info = {12'h70A, 8'h00, 8'h83};
         3: reg_info = {12'h70C, 8'h02, 8'h03};
         4: reg_info = {12'h70D, 8'h0A, 8'hFF};
         5: reg_info = {12'h73C, 8'h00, 8'h37};
         default: reg_info = {12'h700, 8'h00, 8'h00};
      endcase
   endfunction
   // Enabled causes minus any tributary hit by a set disable
   function [NT-1:0] exp_aux(input [7:0] c);
      exp_aux = ((trib_label_mismatch & {NT{extended_defect_mode & c[3]}}) |
         (trib_unequipped & {NT{c[4]}}) | (trib_label_unstable & {NT{c[2]}}))
         & ~((trib_pointer_loss & {NT{c[6]}}) |
         (trib_incoming_alarm & {NT{c[5]}}) |
         (trib_multiframe_loss & {NT{c[7]}}));
   endfunction
   task check(input [31:0] seen, input [31:0] exp);
      begin
         tests_run = tests_run + 1;
         if (seen !== exp) begin
            failures = failures + 1;
            $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
         end
      end
   endtask
   // Bounded wait for hready at the next rising edges
   task wait_ready;
      integer n;
      begin
         n = 0;
         @(posedge clk_sys);
         while (hready !== 1'b1 && n < 20) begin
            @(posedge clk_sys);
            n = n + 1;
         end
         if (n >= 20) begin
            failures = failures + 1;
            report_and_stop;
         end
      end
   endtask
   // One single transfer; an idle cycle always precedes the address phase
   task bus(input w, input [11:0] idx, input [7:0] d);
      begin
         @(posedge clk_sys);
         hsel <= 1'b1;
         htrans <= 2'h2;
         hwrite <= w;
         haddr <= {idx, 2'b00};
         wait_ready;
         hsel <= 1'b0;
         htrans <= 2'h0;
         hwdata <= {24'h0, d};
         wait_ready;
         rd = hrdata;
      end
   endtask
   task pulse(input [7:0] m, input [7:0] d);
      begin
         mon <= m;
         line_drop_data_bus <= d;
         repeat (6) @(posedge clk_sys);
         mon <= 8'h00;
         line_drop_data_bus <= 8'h00;
         repeat (2) @(posedge clk_sys);
      end
   endtask
   task report_and_stop;
      begin
         $display("comparisons %0d mismatches %0d", tests_run, failures);
         if (failures == 0 && tests_run > 0)
            $display("verification passed");
         else
            $display("verification failed");
         $finish;
      end
   endtask
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      repeat (6) @(posedge clk_sys);
      resetn <= 1'b1;
      check(transmit_payload_pointer, 10'h20A);
      for (i = 0; i < 7; i = i + 1) begin
         info = reg_info(i);
         bus(0, info[27:16], 8'h00);
         check(rd, info[15:8]);
      end
      $display("test reset values done");
      for (k = 0; k < 21; k = k + 1) begin
         info = reg_info(k % 7);
         v = $random(seed);
         // Reserved loopback bit is always written low
         if (info[27:16] == 12'h70A) begin
            v[7] = 1'b0;
         end
         bus(1, info[27:16], v);
         bus(0, info[27:16], 8'h00);
         check(rd, v & info[7:0]);
      end
      bus(1, 12'h70C, 8'hFF);
      bus(1, 12'h70D, 8'hFF);
      // The write lands at the edge the task returns on
      @(negedge clk_sys);
      check(transmit_payload_pointer, 10'h3FF);
      bus(1, 12'h70C, 8'h00);
      bus(1, 12'h70D, 8'h00);
      @(negedge clk_sys);
      check(transmit_payload_pointer, 10'h000);
      $display("test register access done");
      for (k = 0; k < 18; k = k + 1) begin
         v = (k < 16) ? $random(seed) : (k[0] ? 8'h1C : 8'hFC);
         bus(1, 12'h708, v);
         extended_defect_mode <= (k < 16) ? $random(seed) : 1'b1;
         trib_label_mismatch <= (k < 16) ? $random(seed) : 8'hFF;
         trib_label_unstable <= (k < 16) ? $random(seed) : 8'hFF;
         trib_unequipped <= (k < 16) ? $random(seed) : 8'hFF;
         trib_pointer_loss <= (k < 16) ? $random(seed) : 8'hFF;
         trib_incoming_alarm <= (k < 16) ? $random(seed) : 8'hFF;
         trib_multiframe_loss <= (k < 16) ? $random(seed) : 8'hFF;
         repeat (2) @(posedge clk_sys);
         check(aux_defect, exp_aux(v));
      end
      $display("test aux defect done");
      bus(1, 12'h70C, 8'h02);
      bus(1, 12'h70D, 8'h0A);
      for (k = 0; k < 2; k = k + 1) begin
         bus(1, 12'h709, k ? 8'h00 : 8'h81);
         bus(1, 12'h70A, k ? 8'h01 : 8'h02);
         bus(1, 12'h73C, k ? 8'h00 : 8'h04);
         repeat (20) @(posedge clk_sys);
         check({fast_ref_freq_select, system_frame_pulse_select,
            diag_loopback_en, line_loopback_en, delay_line_error_irq_en},
            k ? 5'b00010 : 5'b11101);
         // Error seen at one negedge shows on the pin by the next
         @(negedge clk_sys);
         for (i = 0; i < 8; i = i + 1) begin
            v[0] = delay_line_error;
            @(negedge clk_sys);
            check(interrupt_out_n, !(!k[0] && v[0]));
         end
      end
      $display("test configuration done");
      bus(0, 12'h70B, 8'h00);
      for (i = 0; i < 8; i = i + 1) begin
         if (i != 4) begin
            pulse(8'h01 << i, 8'h00);
            bus(0, 12'h70B, 8'h00);
            check(rd, 8'h01 << i);
            bus(0, 12'h70B, 8'h00);
            check(rd, 8'h00);
         end
      end
      pulse(8'h00, 8'h7F);
      bus(0, 12'h70B, 8'h00);
      check(rd, 8'h00);
      pulse(8'h00, 8'h80);
      bus(0, 12'h70B, 8'h00);
      check(rd, 8'h00);
      pulse(8'h00, 8'h7F);
      pulse(8'h01, 8'h80);
      bus(1, 12'h70B, 8'hFF);
      @(negedge clk_sys);
      check(accum_trigger, 1'b1);
      bus(0, 12'h70B, 8'h00);
      check(rd, 8'h11);
      $display("test signal monitor done");
      report_and_stop;
   end
endmodule // smcr_regs_tb_top
